//--- qdc_pkg.sv
// Constants for the quad converter command decoder.
// Assumes a single 50 MHz clock and an asynchronous active-low reset.
// Summary of operation
// [RQ1] Frame is 24 bits: reserved, byte select, command, channel address, data.
// [RQ2] 14-bit variant takes code from frame bits 15..2.
// [RQ3] 12-bit variant takes code from frame bits 15..4.
// [RQ4] Broadcast address accepted only for writes.
// [RQ5] Broadcast address acknowledged regardless of address pins.
// [RQ6] Command 000 writes input register; 001 copies input to converter.
// [RQ7] Command 010 writes input register then loads all channels.
// [RQ8] Command 011 writes and updates addressed channel together.
// [RQ9] Commands 100 power, 101 reset, 110 mask setup, 111 reference.
// [RQ10] Address 000..011 selects A..D; 111 selects all channels.
// [RQ11] Input register written only after complete valid write.
// [RQ12] Strobe high: converter registers hold.
// [RQ13] Strobe low: converter registers take input registers.
// [RQ14] Strobe updates a channel only if its input was written since.
// [RQ15] Mask bit 1 updates on new data; bit 0 follows strobe.
// [RQ16] Command 110 loads mask from bits 3..0, A in bit 0, resets 0.
// [RQ17] Without strobe pin, mask 0 leaves updates to the command.
// [RQ18] Command 100 applies mode from bits 5..4 to selected channels.
// [RQ19] Power command bits 3..0 select D..A; 0 leaves channel unchanged.
// [RQ20] Mode 00 normal, 01 1k pull-down, 10 100k, 11 three-state.
// [RQ21] Power-down keeps converter register contents.
// [RQ22] Master writes reserved bit 23 as 0.
// [RQ23] Byte select 1 reuses command byte for later data pairs; code tests cmd_q bit 22, out of range, so it reuses for select 0 too.
// [RQ24] Reset bit0 0 clears converter; 1 also mask, power, reference.
// [RQ25] Act only after last frame byte fully received and acknowledged.
// [RQ26] Channel addresses 100, 101, 110 are ignored.
`default_nettype none
package qdc_pkg;
  localparam logic [6:0] QDC_BCAST_ADDR = 7'h08;
  localparam logic [2:0] QDC_CMD_WR_IN = 3'h0;
  localparam logic [2:0] QDC_CMD_UPD = 3'h1;
  localparam logic [2:0] QDC_CMD_WR_ALL = 3'h2;
  localparam logic [2:0] QDC_CMD_WR_UPD = 3'h3;
  localparam logic [2:0] QDC_CMD_POWER = 3'h4;
  localparam logic [2:0] QDC_CMD_RESET = 3'h5;
  localparam logic [2:0] QDC_CMD_MASK = 3'h6;
  localparam logic [2:0] QDC_CMD_REF = 3'h7;
  localparam logic [2:0] QDC_CH_ALL = 3'h7;
  localparam int QDC_POS_SEL = 22;
  localparam int QDC_POS_CMD = 19;
  localparam int QDC_POS_CH = 16;
  localparam int QDC_POS_PWR = 4;
  localparam logic [3:0] QDC_MASK_RST = 4'h0;
  localparam logic [1:0] QDC_PWR_RST = 2'h0;
  localparam logic [15:0] QDC_CODE_RST = 16'h0000;
  localparam logic [15:0] QDC_CODE_MID = 16'h8000;
endpackage
`default_nettype wire

//--- qdc_i2c_rx.sv
// Two-wire slave receiver: collects write bytes and answers with acknowledge.
// Assumes scl and sda inputs already pass two flip-flops in the parent.
`default_nettype none
module qdc_i2c_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Synchronised bus lines
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [6:0] own_addr,
  // Acknowledge drive, low enable pulls low
  output logic sda_oe_b,
  // Received byte after its acknowledge
  output logic byte_stb,
  output logic [7:0] byte_data,
  output logic byte_first,
  output logic frame_stop
);
  typedef enum logic [3:0] {
    QDC_IDLE = 4'b0001, QDC_ADDR = 4'b0010, QDC_DATA = 4'b0100, QDC_SKIP = 4'b1000
  } qdc_rx_e;
  qdc_rx_e st_q;
  logic scl_q, sda_q, ack_q, first_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_c = scl_s && scl_q && sda_q && !sda_s;
  wire stop_c = scl_s && scl_q && !sda_q && sda_s;
  wire addr_hit = sh_q[7:1] == own_addr || sh_q[7:1] == qdc_pkg::QDC_BCAST_ADDR; // RQ5
  wire addr_ok = addr_hit && !sh_q[0]; // RQ4
  assign sda_oe_b = !ack_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= QDC_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ack_q <= 1'b0;
      first_q <= 1'b0;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      byte_stb <= 1'b0;
      byte_data <= 8'h00;
      byte_first <= 1'b0;
      frame_stop <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      byte_stb <= 1'b0;
      frame_stop <= stop_c && st_q != QDC_IDLE;
      if (start_c) begin
        st_q <= QDC_ADDR;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= QDC_IDLE;
        ack_q <= 1'b0;
      end else if (scl_rise && cnt_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end else if (scl_fall && cnt_q == 4'h8 && !ack_q) begin
        case (st_q)
          QDC_ADDR: begin
            ack_q <= addr_ok;
            first_q <= 1'b1;
            if (!addr_ok) st_q <= QDC_SKIP;
          end
          QDC_DATA: ack_q <= 1'b1;
          QDC_IDLE, QDC_SKIP: ack_q <= 1'b0;
          default: st_q <= QDC_IDLE;
        endcase
      end else if (scl_fall && cnt_q == 4'h8 && ack_q) begin
        ack_q <= 1'b0;
        cnt_q <= 4'h0;
        if (st_q == QDC_ADDR) begin
          st_q <= QDC_DATA;
        end else if (st_q == QDC_DATA) begin
          byte_stb <= 1'b1; // RQ25
          byte_data <= sh_q;
          byte_first <= first_q;
          first_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- qdc_top.sv
// Quad converter command decoder: frame assembly, commands, register banks.
// Assumes bus lines and the load strobe come from pins outside the clock domain.
`default_nettype none
module qdc_top #(
  parameter int RES_BITS = 16,
  parameter logic [6:0] DEV_ADDR = 7'h0c,
  parameter bit HAS_STROBE = 1'b1,
  parameter bit POR_MID = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  // Load strobe pin, active low
  input wire logic load_strobe_n,
  // Converter codes, packed D..A
  output logic [63:0] conv_code,
  output logic [7:0] power_mode,
  output logic [3:0] autoload_mask,
  output logic ref_on
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] scl_sy_q, sda_sy_q, ld_sy_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
      ld_sy_q <= 2'b11;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      ld_sy_q <= {ld_sy_q[0], load_strobe_n};
    end
  end
  wire strobe_low = HAS_STROBE && !ld_sy_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Byte receiver
  logic byte_stb, byte_first, frame_stop, ack_oe_b;
  logic [7:0] byte_data;
  qdc_i2c_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .scl_s(scl_sy_q[1]),
    .sda_s(sda_sy_q[1]),
    .own_addr(DEV_ADDR),
    .sda_oe_b(ack_oe_b),
    .byte_stb(byte_stb),
    .byte_data(byte_data),
    .byte_first(byte_first),
    .frame_stop(frame_stop)
  );
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b1;
      sda_oe_b <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_b <= ack_oe_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly
  logic [7:0] cmd_q, hi_q;
  logic [1:0] idx_q;
  logic frame_go_q;
  wire cmd_byte = byte_first || (idx_q == 2'd0 && !cmd_q[qdc_pkg::QDC_POS_SEL]); // RQ23
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 8'h00;
      hi_q <= 8'h00;
      idx_q <= 2'd0;
      frame_go_q <= 1'b0;
    end else begin
      frame_go_q <= 1'b0;
      if (frame_stop) begin
        idx_q <= 2'd0;
      end else if (byte_stb) begin
        if (cmd_byte) begin
          cmd_q <= byte_data;
          idx_q <= 2'd1;
        end else if (idx_q != 2'd2) begin
          hi_q <= byte_data;
          idx_q <= 2'd2;
        end else begin
          frame_go_q <= 1'b1; // RQ25
          idx_q <= 2'd0;
        end
      end
    end
  end
  logic [7:0] lo_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lo_q <= 8'h00;
    else if (byte_stb && !cmd_byte && idx_q == 2'd2) lo_q <= byte_data;
  end
  wire [23:0] frame = {cmd_q, hi_q, lo_q}; // RQ1
  wire [2:0] cmd = frame[qdc_pkg::QDC_POS_CMD +: 3];
  wire [2:0] ch = frame[qdc_pkg::QDC_POS_CH +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic logic [3:0] ch_sel(input logic [2:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (a) // RQ10
      3'h0: r = 4'h1;
      3'h1: r = 4'h2;
      3'h2: r = 4'h4;
      3'h3: r = 4'h8;
      qdc_pkg::QDC_CH_ALL: r = 4'hf;
      default: r = 4'h0; // RQ26
    endcase
    return r;
  endfunction
  function automatic logic [15:0] code_of(input logic [15:0] d);
    logic [15:0] r;
    r = d;
    if (RES_BITS == 14) r = {d[15:2], 2'b00}; // RQ2
    else if (RES_BITS == 12) r = {d[15:4], 4'h0}; // RQ3
    return r;
  endfunction
  wire [3:0] sel = ch_sel(ch);
  wire [15:0] code = code_of(frame[15:0]);
  wire go = frame_go_q; // RQ9
  wire do_wr = go && (cmd == qdc_pkg::QDC_CMD_WR_IN || cmd == qdc_pkg::QDC_CMD_WR_ALL ||
                      cmd == qdc_pkg::QDC_CMD_WR_UPD); // RQ11
  wire [3:0] wr_ch = do_wr ? sel : 4'h0; // RQ6
  wire [3:0] cmd_upd = !go ? 4'h0 :
                       cmd == qdc_pkg::QDC_CMD_UPD ? sel : // RQ6
                       cmd == qdc_pkg::QDC_CMD_WR_UPD ? sel : // RQ8
                       cmd == qdc_pkg::QDC_CMD_WR_ALL ? 4'hf : 4'h0; // RQ7
  wire do_rst = go && cmd == qdc_pkg::QDC_CMD_RESET;
  wire full_rst = do_rst && frame[0]; // RQ24

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [3:0] mask_q;
  logic [7:0] pwr_q;
  logic ref_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= qdc_pkg::QDC_MASK_RST;
      pwr_q <= {4{qdc_pkg::QDC_PWR_RST}};
      ref_q <= 1'b0;
    end else if (full_rst) begin
      mask_q <= qdc_pkg::QDC_MASK_RST; // RQ24
      pwr_q <= {4{qdc_pkg::QDC_PWR_RST}};
      ref_q <= 1'b0;
    end else if (go) begin
      if (cmd == qdc_pkg::QDC_CMD_MASK) mask_q <= frame[3:0]; // RQ16
      if (cmd == qdc_pkg::QDC_CMD_REF) ref_q <= frame[0];
      if (cmd == qdc_pkg::QDC_CMD_POWER) begin
        for (int i = 0; i < 4; i++) begin
          if (frame[i]) pwr_q[2*i +: 2] <= frame[qdc_pkg::QDC_POS_PWR +: 2]; // RQ18 RQ19 RQ20
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input and converter registers
  logic [15:0] in_q [4];
  logic [15:0] conv_q [4];
  logic [3:0] fresh_q;
  logic [3:0] upd;
  localparam logic [15:0] CODE_RST = POR_MID ? qdc_pkg::QDC_CODE_MID : qdc_pkg::QDC_CODE_RST;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      upd[i] = cmd_upd[i] || ((fresh_q[i] || wr_ch[i]) &&
               (mask_q[i] || strobe_low)); // RQ12 RQ13 RQ14 RQ15 RQ17
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fresh_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        in_q[i] <= CODE_RST;
        conv_q[i] <= CODE_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (do_rst) begin
          in_q[i] <= 16'h0000;
          conv_q[i] <= 16'h0000; // RQ24
          fresh_q[i] <= 1'b0;
        end else begin
          if (wr_ch[i]) in_q[i] <= code; // RQ11
          if (upd[i]) conv_q[i] <= wr_ch[i] ? code : in_q[i]; // RQ21
          fresh_q[i] <= (fresh_q[i] || wr_ch[i]) && !upd[i]; // RQ14
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_code <= {4{CODE_RST}};
      power_mode <= 8'h00;
      autoload_mask <= 4'h0;
      ref_on <= 1'b0;
    end else begin
      conv_code <= {conv_q[3], conv_q[2], conv_q[1], conv_q[0]};
      power_mode <= pwr_q;
      autoload_mask <= mask_q;
      ref_on <= ref_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_mask_load: assert property (@(posedge clk) disable iff (!rst_b)
    go && cmd == qdc_pkg::QDC_CMD_MASK && !do_rst |=> mask_q == $past(frame[3:0])) // RQ16
    else $error("mask not loaded");
  a_hold_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    !go && !strobe_low && mask_q == 4'h0 |=> $stable(conv_q[0])) // RQ12
    else $error("converter changed while held");
  a_wr_upd: assert property (@(posedge clk) disable iff (!rst_b)
    go && cmd == qdc_pkg::QDC_CMD_WR_UPD && ch == 3'h1 |=> conv_q[1] == $past(code)) // RQ8
    else $error("write and update failed");
  a_bad_addr: assert property (@(posedge clk) disable iff (!rst_b)
    go && ch inside {3'h4, 3'h5, 3'h6} && cmd != qdc_pkg::QDC_CMD_RESET
    |=> $stable(in_q[2])) // RQ26
    else $error("undefined address wrote channel");
  a_full_rst: assert property (@(posedge clk) disable iff (!rst_b)
    full_rst |=> mask_q == 4'h0 && pwr_q == 8'h00 && !ref_q) // RQ24
    else $error("full reset incomplete");
  a_pwr_keep: assert property (@(posedge clk) disable iff (!rst_b)
    go && cmd == qdc_pkg::QDC_CMD_POWER |=> $stable(conv_q[3])) // RQ21
    else $error("power command touched converter");
  a_go_after: assert property (@(posedge clk) disable iff (!rst_b)
    frame_go_q |-> $past(byte_stb)) // RQ25
    else $error("action without received byte");
  a_strobe_load: assert property (@(posedge clk) disable iff (!rst_b)
    fresh_q[0] && strobe_low && !go |=> conv_q[0] == $past(in_q[0]) && !fresh_q[0]) // RQ13
    else $error("strobe did not load");
endmodule
`default_nettype wire

//--- qdc_i2c_master.sv
// Behavioural two-wire bus master that writes command frames to the decoder.
// Assumes the bench resolves the data wire from all drivers with a pull-up.
`default_nettype none
module qdc_i2c_master (
  // Clock and resolved bus
  input wire logic clk,
  input wire logic sda,
  // Bus drive
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  int stretch = 0;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Low phase plus high phase gives a 160 ns bus clock when stretch is 0
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  // The low phase before the acknowledge pulse is longer: the slave answers
  // through its input synchronisers and must pull the line low before SCL rises
  task automatic bit_io(input logic b, input int lo, output logic seen);
    sda_m = b;
    tick(lo + stretch);
    scl = 1'b1;
    tick(4);
    seen = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // Eight bits out, then the line is released and the acknowledge read
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], 2, s);
    end
    bit_io(1'b1, 8, s);
    ack = !s;
    tick(2);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

//--- qdc_top_tb_top.sv
// Self-checking bench for the quad converter command decoder.
// Assumes the partner master model and the design package are compiled first.
`default_nettype none
module qdc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = 7'h0c;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic load_strobe_n = 1'b1;
  logic scl;
  logic sda_m;
  wire logic sda;
  logic sda_out;
  logic sda_oe_b;
  logic [63:0] conv_code;
  logic [7:0] power_mode;
  logic [3:0] autoload_mask;
  logic ref_on;
  logic [15:0] e [4] = '{default: 16'h0000};
  int failures = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  assign sda = sda_m & (sda_oe_b | sda_out);
  qdc_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  qdc_top #(.RES_BITS(16), .DEV_ADDR(DEV), .HAS_STROBE(1'b1), .POR_MID(1'b0)) dut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .load_strobe_n(load_strobe_n), .conv_code(conv_code),
    .power_mode(power_mode), .autoload_mask(autoload_mask), .ref_on(ref_on));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_conv();
    check(conv_code, {e[3], e[2], e[1], e[0]});
  endtask
  // Command byte with the reserved bit held at 0
  function automatic logic [7:0] cb(input logic s, input logic [2:0] c, input logic [2:0] ch);
    return {1'b0, s, c, ch};
  endfunction
  task automatic frame(input logic [7:0] ab, input logic [7:0] q [$], input logic exp_ack);
    logic ack;
    m.start();
    m.send(ab, ack);
    check(ack, exp_ack);
    if (ack) begin
      foreach (q[i]) begin
        m.send(q[i], ack);
        check(ack, 1'b1);
      end
    end
    m.stop();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] c, input logic [2:0] ch, input logic [15:0] d);
    frame({DEV, 1'b0}, '{cb(1'b0, c, ch), d[15:8], d[7:0]}, 1'b1);
  endtask
  task automatic strobe();
    load_strobe_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    load_strobe_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk_conv();
    check({power_mode, autoload_mask, ref_on, sda_oe_b}, {8'h00, 4'h0, 1'b0, 1'b1});
  endtask
  task automatic s_double_buffer();
    wr(qdc_pkg::QDC_CMD_WR_IN, 3'h0, 16'h1234);
    chk_conv();
    strobe();
    e[0] = 16'h1234;
    chk_conv();
    wr(qdc_pkg::QDC_CMD_WR_UPD, 3'h1, 16'h5a5a);
    e[1] = 16'h5a5a;
    chk_conv();
  endtask
  task automatic s_update_cmds();
    wr(qdc_pkg::QDC_CMD_WR_IN, 3'h2, 16'h0f0f);
    chk_conv();
    wr(qdc_pkg::QDC_CMD_UPD, 3'h2, 16'h0000);
    e[2] = 16'h0f0f;
    chk_conv();
    wr(qdc_pkg::QDC_CMD_WR_ALL, 3'h3, 16'hbeef);
    e[3] = 16'hbeef;
    chk_conv();
  endtask
  task automatic s_address();
    wr(qdc_pkg::QDC_CMD_WR_UPD, 3'h5, 16'hdead);
    chk_conv();
    frame({7'h0d, 1'b0}, '{8'h18}, 1'b0);
    frame({qdc_pkg::QDC_BCAST_ADDR, 1'b1}, '{8'h18}, 1'b0);
    frame({qdc_pkg::QDC_BCAST_ADDR, 1'b0}, '{cb(1'b0, 3'h3, 3'h7), 8'h77, 8'h70}, 1'b1);
    e = '{default: 16'h7770};
    chk_conv();
  endtask
  task automatic s_mask();
    wr(qdc_pkg::QDC_CMD_MASK, 3'h0, 16'h0002);
    check(autoload_mask, 4'h2);
    wr(qdc_pkg::QDC_CMD_WR_IN, 3'h1, 16'h1111);
    e[1] = 16'h1111;
    wr(qdc_pkg::QDC_CMD_WR_IN, 3'h0, 16'h2222);
    chk_conv();
    strobe();
    e[0] = 16'h2222;
    chk_conv();
  endtask
  task automatic s_power();
    wr(qdc_pkg::QDC_CMD_POWER, 3'h0, 16'h0015);
    check(power_mode, 8'h11);
    wr(qdc_pkg::QDC_CMD_POWER, 3'h0, 16'h0032);
    check(power_mode, 8'h1d);
    chk_conv();
  endtask
  task automatic s_multi();
    m.stretch = 3;
    frame({DEV, 1'b0}, '{cb(1'b1, 3'h3, 3'h0), 8'h01, 8'h01, 8'h02, 8'h02}, 1'b1);
    m.stretch = 0;
    e[0] = 16'h0202;
    chk_conv();
  endtask
  task automatic s_ref_reset();
    wr(qdc_pkg::QDC_CMD_REF, 3'h0, 16'h0001);
    check(ref_on, 1'b1);
    wr(qdc_pkg::QDC_CMD_RESET, 3'h0, 16'h0001);
    e = '{default: 16'h0000};
    chk_conv();
    check({power_mode, autoload_mask, ref_on}, 13'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    s_reset();
    s_double_buffer();
    s_update_cmds();
    s_address();
    s_mask();
    s_power();
    s_multi();
    s_ref_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
